//--- hw/spiiw_top.sv
// Top: SPI interrupt enable, wake flags/enables and activity status with AXI4-Lite slave
//
// Notes on behaviour
// - Enable bits 15 and 14 gate receive underrun and overrun interrupts.
// - Enable bits 13 and 12 gate transmit underrun and overrun interrupts.
// - Enable bit 11 gates the master transfer-complete interrupt.
// - Enable bits 9 and 8 gate slave abort and multi-master fault.
// - Enable bits 5 and 4 gate slave-select deassert and assert.
// - Enable bits 3..0 gate rx full, rx threshold, tx empty, tx threshold.
// - Wake flags 3 and 2 set on rx full/threshold; write one clears.
// - Wake flags 1 and 0 set on tx empty/threshold; write one clears.
// - Wake enables 3 and 2 gate rx full and rx threshold wakeups.
// - Wake enables 1 and 0 gate tx empty and tx threshold wakeups.
// - Master mode: busy sets on transaction start, clears after last character.
// - Slave mode: busy follows the configured slave-select input.
// - Receive overrun only counts in slave mode; master stalls instead.
// - Transmit threshold flag follows level below threshold, cleared by hardware.
`timescale 1ns/1ps
module spiiw_top
  import spiiw_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              mclk_in,
  input  wire logic              rst_n_in,
  // AXI4-Lite write address
  input  wire logic              s_axi_awvalid_in,
  output logic                   s_axi_awready_out,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  // AXI4-Lite write data
  input  wire logic              s_axi_wvalid_in,
  output logic                   s_axi_wready_out,
  input  wire logic [31:0]       s_axi_wdata_in,
  input  wire logic [3:0]        s_axi_wstrb_in,
  // AXI4-Lite write response
  output logic                   s_axi_bvalid_out,
  input  wire logic              s_axi_bready_in,
  output logic [1:0]             s_axi_bresp_out,
  // AXI4-Lite read address
  input  wire logic              s_axi_arvalid_in,
  output logic                   s_axi_arready_out,
  input  wire logic [ADDR_W-1:0] s_axi_araddr_in,
  // AXI4-Lite read data
  output logic                   s_axi_rvalid_out,
  input  wire logic              s_axi_rready_in,
  output logic [31:0]            s_axi_rdata_out,
  output logic [1:0]             s_axi_rresp_out,
  // Controller events
  input  wire spiiw_core_s       core_in,
  // Requests
  output logic                   irq_out,
  output logic                   wake_out,
  output logic                   busy_out
);

  // Decode reads byte-address bits 7:2, so narrower buses cannot work
  if (ADDR_W < 8) begin : g_addr_w_check
    $error("ADDR_W must be at least 8");
  end

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [15:0] irq_en_q, irq_en_d;
  logic [3:0]  wake_fl_q, wake_fl_d;
  logic [3:0]  wake_en_q, wake_en_d;
  logic [1:0]  blk_fl_q, blk_fl_d;     // Own events: bit 1 busy fall, bit 0 busy rise
  logic [1:0]  blk_mask_q, blk_mask_d;
  logic        busy_prev_q;
  logic        irq_q, irq_d;
  logic        wake_q, wake_d;
  logic        busy_q;
  logic        busy_now;

  // Bus state
  logic              aw_full_q, aw_full_d;
  logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
  logic              w_full_q, w_full_d;
  logic [31:0]       w_data_q, w_data_d;
  logic [3:0]        w_strb_q, w_strb_d;
  logic              bvalid_q, bvalid_d;
  logic [1:0]        bresp_q, bresp_d;
  logic              rvalid_q, rvalid_d;
  logic [31:0]       rdata_q, rdata_d;
  logic [1:0]        rresp_q, rresp_d;
  // Ready flags kept in flops so each bus output comes from a register
  logic              awready_q;
  logic              wready_q;
  logic              arready_q;

  // ----------------------------------------------------------------
  // Activity tracker
  // ----------------------------------------------------------------
  spiiw_activity u_activity (
    .mclk_in        (mclk_in),
    .rst_n_in       (rst_n_in),
    .master_mode_in (core_in.master_mode),
    .xfer_start_in  (core_in.xfer_start),
    .last_char_in   (core_in.last_char),
    .ss_active_in   (core_in.ss_active),
    .busy_out       (busy_now)
  );

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  logic        wr_go;
  logic [7:0]  wr_off;
  logic [31:0] wr_bits;
  logic        wr_hit;

  // Unstrobed byte lanes write zero
  for (genvar g = 0; g < 4; g++) begin : g_lane
    assign wr_bits[g*8 +: 8] = w_strb_q[g] ? w_data_q[g*8 +: 8] : 8'h00;
  end

  always_comb begin
    aw_full_d = aw_full_q;
    aw_addr_d = aw_addr_q;
    w_full_d  = w_full_q;
    w_data_d  = w_data_q;
    w_strb_d  = w_strb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    if (s_axi_awvalid_in && !aw_full_q) begin
      aw_full_d = 1'b1;
      aw_addr_d = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && !w_full_q) begin
      w_full_d = 1'b1;
      w_data_d = s_axi_wdata_in;
      w_strb_d = s_axi_wstrb_in;
    end
    // Write lands once address and data are both held, one response at a time
    wr_go  = aw_full_q && w_full_q && !bvalid_q;
    wr_off = {aw_addr_q[7:2], 2'b00};
    wr_hit = (wr_off == SPIIW_OFF_IRQ_EN)  || (wr_off == SPIIW_OFF_WAKE_FL) ||
             (wr_off == SPIIW_OFF_WAKE_EN) || (wr_off == SPIIW_OFF_STATUS) ||
             (wr_off == SPIIW_OFF_EVT_FL)  || (wr_off == SPIIW_OFF_EVT_MASK);
    if (wr_go) begin
      aw_full_d = 1'b0;
      w_full_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = wr_hit ? SPIIW_RESP_OKAY : SPIIW_RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready_in) begin
      bvalid_d = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Register update
  // ----------------------------------------------------------------
  logic [1:0] blk_evt;

  always_comb begin
    irq_en_d   = irq_en_q;
    wake_en_d  = wake_en_q;
    blk_mask_d = blk_mask_q;
    wake_fl_d  = wake_fl_q;
    blk_fl_d   = blk_fl_q;
    blk_evt    = {busy_prev_q && !busy_now, !busy_prev_q && busy_now};
    if (wr_go && wr_off == SPIIW_OFF_IRQ_EN) begin
      irq_en_d = wr_bits[15:0] & SPIIW_IRQ_EN_MASK;
    end
    if (wr_go && wr_off == SPIIW_OFF_WAKE_EN) begin
      wake_en_d = wr_bits[3:0] & SPIIW_WAKE_MASK;
    end
    if (wr_go && wr_off == SPIIW_OFF_EVT_MASK) begin
      blk_mask_d = wr_bits[1:0];
    end
    if (wr_go && wr_off == SPIIW_OFF_WAKE_FL) begin
      wake_fl_d = wake_fl_q & ~wr_bits[3:0];
    end
    if (wr_go && wr_off == SPIIW_OFF_EVT_FL) begin
      blk_fl_d = blk_fl_q & ~wr_bits[1:0];
    end
    wake_fl_d = wake_fl_d | core_in.wake_cond;
    blk_fl_d  = blk_fl_d | blk_evt;
  end

  // ----------------------------------------------------------------
  // Request outputs
  // ----------------------------------------------------------------
  logic [15:0] evt_gated;

  always_comb begin
    evt_gated = core_in.evt_flags & SPIIW_IRQ_EN_MASK;
    // Master mode stalls the clock, so overrun cannot count there
    if (core_in.master_mode) begin
      evt_gated[SPIIW_B_RX_OVERRUN] = 1'b0;
    end
    // Threshold flag is a live level owned by the controller
    evt_gated[SPIIW_B_TX_THD] = core_in.evt_flags[SPIIW_B_TX_THD];
    irq_d  = |(evt_gated & irq_en_q) | |(blk_fl_q & blk_mask_q);
    wake_d = |(wake_fl_q & wake_en_q);
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  logic [7:0] rd_off;

  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    rd_off   = {s_axi_araddr_in[7:2], 2'b00};
    // One read outstanding: address taken only while no data waits
    if (s_axi_arvalid_in && !rvalid_q) begin
      rvalid_d = 1'b1;
      rresp_d  = SPIIW_RESP_OKAY;
      unique case (rd_off)
        SPIIW_OFF_IRQ_EN:   rdata_d = {16'h0000, irq_en_q};
        SPIIW_OFF_WAKE_FL:  rdata_d = {28'h0000000, wake_fl_q};
        SPIIW_OFF_WAKE_EN:  rdata_d = {28'h0000000, wake_en_q};
        SPIIW_OFF_STATUS:   rdata_d = {31'h00000000, busy_q};
        SPIIW_OFF_EVT_FL:   rdata_d = {30'h00000000, blk_fl_q};
        SPIIW_OFF_EVT_MASK: rdata_d = {30'h00000000, blk_mask_q};
        default: begin
          rdata_d = 32'h00000000;
          rresp_d = SPIIW_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && s_axi_rready_in) begin
      rvalid_d = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      irq_en_q    <= SPIIW_RST_IRQ_EN;
      wake_fl_q   <= SPIIW_RST_WAKE_FL;
      wake_en_q   <= SPIIW_RST_WAKE_EN;
      blk_fl_q    <= SPIIW_RST_BLK_EVT;
      blk_mask_q  <= SPIIW_RST_BLK_EVT;
      busy_prev_q <= SPIIW_RST_BUSY;
      busy_q      <= SPIIW_RST_BUSY;
      irq_q       <= 1'b0;
      wake_q      <= 1'b0;
      aw_full_q   <= 1'b0;
      aw_addr_q   <= '0;
      w_full_q    <= 1'b0;
      w_data_q    <= 32'h00000000;
      w_strb_q    <= 4'h0;
      bvalid_q    <= 1'b0;
      bresp_q     <= SPIIW_RESP_OKAY;
      rvalid_q    <= 1'b0;
      rdata_q     <= 32'h00000000;
      rresp_q     <= SPIIW_RESP_OKAY;
      awready_q   <= 1'b1;
      wready_q    <= 1'b1;
      arready_q   <= 1'b1;
    end else begin
      irq_en_q    <= irq_en_d;
      wake_fl_q   <= wake_fl_d;
      wake_en_q   <= wake_en_d;
      blk_fl_q    <= blk_fl_d;
      blk_mask_q  <= blk_mask_d;
      busy_prev_q <= busy_now;
      busy_q      <= busy_now;
      irq_q       <= irq_d;
      wake_q      <= wake_d;
      aw_full_q   <= aw_full_d;
      aw_addr_q   <= aw_addr_d;
      w_full_q    <= w_full_d;
      w_data_q    <= w_data_d;
      w_strb_q    <= w_strb_d;
      bvalid_q    <= bvalid_d;
      bresp_q     <= bresp_d;
      rvalid_q    <= rvalid_d;
      rdata_q     <= rdata_d;
      rresp_q     <= rresp_d;
      awready_q   <= !aw_full_d;
      wready_q    <= !w_full_d;
      arready_q   <= !rvalid_d;
    end
  end

  // ----------------------------------------------------------------
  // Port drive
  // ----------------------------------------------------------------
  assign s_axi_awready_out = awready_q;
  assign s_axi_wready_out  = wready_q;
  assign s_axi_bvalid_out  = bvalid_q;
  assign s_axi_bresp_out   = bresp_q;
  assign s_axi_arready_out = arready_q;
  assign s_axi_rvalid_out  = rvalid_q;
  assign s_axi_rdata_out   = rdata_q;
  assign s_axi_rresp_out   = rresp_q;
  assign irq_out           = irq_q;
  assign wake_out          = wake_q;
  assign busy_out          = busy_q;

endmodule

//--- hw/spiiw_pkg.sv
// Package: register map, field layout and shared types of the SPI interrupt/wake/status block
package spiiw_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] SPIIW_OFF_IRQ_EN   = 8'h24;
  localparam logic [7:0] SPIIW_OFF_WAKE_FL  = 8'h28;
  localparam logic [7:0] SPIIW_OFF_WAKE_EN  = 8'h2C;
  localparam logic [7:0] SPIIW_OFF_STATUS   = 8'h30;
  localparam logic [7:0] SPIIW_OFF_EVT_FL   = 8'h34;
  localparam logic [7:0] SPIIW_OFF_EVT_MASK = 8'h38;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SPIIW_B_RX_UNDERRUN  = 15;
  localparam int SPIIW_B_RX_OVERRUN   = 14;
  localparam int SPIIW_B_TX_UNDERRUN  = 13;
  localparam int SPIIW_B_TX_OVERRUN   = 12;
  localparam int SPIIW_B_MST_DONE     = 11;
  localparam int SPIIW_B_ABORT        = 9;
  localparam int SPIIW_B_FAULT        = 8;
  localparam int SPIIW_B_SS_DEASSERT  = 5;
  localparam int SPIIW_B_SS_ASSERT    = 4;
  localparam int SPIIW_B_RX_FULL      = 3;
  localparam int SPIIW_B_RX_THD       = 2;
  localparam int SPIIW_B_TX_EMPTY     = 1;
  localparam int SPIIW_B_TX_THD       = 0;
  localparam int SPIIW_B_BUSY         = 0;

  // Writable / implemented bits
  localparam logic [15:0] SPIIW_IRQ_EN_MASK = 16'hFB3F;
  localparam logic [3:0]  SPIIW_WAKE_MASK   = 4'hF;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] SPIIW_RST_IRQ_EN  = 16'h0000;
  localparam logic [3:0]  SPIIW_RST_WAKE_FL = 4'h0;
  localparam logic [3:0]  SPIIW_RST_WAKE_EN = 4'h0;
  localparam logic        SPIIW_RST_BUSY    = 1'b0;
  localparam logic [1:0]  SPIIW_RST_BLK_EVT = 2'h0;

  // AXI responses
  localparam logic [1:0] SPIIW_RESP_OKAY   = 2'h0;
  localparam logic [1:0] SPIIW_RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] evt_flags;   // Event flag register bits from the controller
    logic [3:0]  wake_cond;   // Wake conditions: rx_full, rx_thd, tx_empty, tx_thd
    logic        master_mode;
    logic        xfer_start;  // Master transaction begins (pulse)
    logic        last_char;   // Master last character sent (pulse)
    logic        ss_active;   // Configured slave-select asserted (level)
  } spiiw_core_s;

  typedef enum logic [1:0] {
    SPIIW_ACT_IDLE   = 2'b00,
    SPIIW_ACT_MASTER = 2'b01,
    SPIIW_ACT_SLAVE  = 2'b10
  } spiiw_act_e;

endpackage

//--- hw/spiiw_activity.sv
// Activity tracker: busy indication for master and slave modes
`timescale 1ns/1ps
module spiiw_activity
  import spiiw_pkg::*;
(
  // Clock and reset
  input  wire logic mclk_in,
  input  wire logic rst_n_in,
  // Controller state
  input  wire logic master_mode_in,
  input  wire logic xfer_start_in,
  input  wire logic last_char_in,
  input  wire logic ss_active_in,
  // Status
  output logic      busy_out
);

  spiiw_act_e state_q;
  spiiw_act_e state_d;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      SPIIW_ACT_IDLE: begin
        if (master_mode_in && xfer_start_in) begin
          state_d = SPIIW_ACT_MASTER;
        end else if (!master_mode_in && ss_active_in) begin
          state_d = SPIIW_ACT_SLAVE;
        end
      end
      SPIIW_ACT_MASTER: begin
        if (last_char_in || !master_mode_in) begin
          state_d = SPIIW_ACT_IDLE;
        end
      end
      SPIIW_ACT_SLAVE: begin
        if (!ss_active_in || master_mode_in) begin
          state_d = SPIIW_ACT_IDLE;
        end
      end
      default: state_d = SPIIW_ACT_IDLE;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      state_q <= SPIIW_ACT_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  assign busy_out = (state_q != SPIIW_ACT_IDLE);

endmodule

//--- test/spiiw_chk.sv
// Checker: port-level properties of the interrupt, wake and activity block
`timescale 1ns/1ps
module spiiw_chk
  import spiiw_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic        mclk_in,
  input wire logic        rst_n_in,
  // Register bus handshakes
  input wire logic        s_axi_awvalid_in,
  input wire logic        s_axi_awready_out,
  input wire logic        s_axi_wvalid_in,
  input wire logic        s_axi_wready_out,
  input wire logic        s_axi_bvalid_out,
  input wire logic        s_axi_bready_in,
  input wire logic        s_axi_arvalid_in,
  input wire logic        s_axi_arready_out,
  input wire logic        s_axi_rvalid_out,
  input wire logic        s_axi_rready_in,
  // Controller side
  input wire spiiw_core_s core_in,
  input wire logic        irq_out,
  input wire logic        wake_out,
  input wire logic        busy_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  property p_mst_set;
    core_in.master_mode && core_in.xfer_start && !core_in.last_char |-> ##[1:3] busy_out;
  endproperty
  a_mst_set: assert property (p_mst_set) else $error("busy missed start");
  property p_mst_clr;
    core_in.master_mode && core_in.last_char && !core_in.xfer_start |-> ##[1:3] !busy_out;
  endproperty
  a_mst_clr: assert property (p_mst_clr) else $error("busy stuck after end");
  property p_slv_set;
    (!core_in.master_mode && core_in.ss_active) [*4] |-> busy_out;
  endproperty
  a_slv_set: assert property (p_slv_set) else $error("busy missed select");
  property p_slv_clr;
    (!core_in.master_mode && !core_in.ss_active) [*4] |-> !busy_out;
  endproperty
  a_slv_clr: assert property (p_slv_clr) else $error("busy stuck idle");
  property p_w_resp;
    s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
      |-> ##[1:3] s_axi_bvalid_out;
  endproperty
  a_w_resp: assert property (p_w_resp) else $error("write response missing");
  property p_b_done;
    s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out;
  endproperty
  a_b_done: assert property (p_b_done) else $error("write response repeated");
  property p_r_lat;
    s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out;
  endproperty
  a_r_lat: assert property (p_r_lat) else $error("read data late");
  property p_r_excl;
    s_axi_rvalid_out |-> !s_axi_arready_out;
  endproperty
  a_r_excl: assert property (p_r_excl) else $error("read taken while busy");
  property p_r_done;
    s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out;
  endproperty
  a_r_done: assert property (p_r_done) else $error("read data repeated");

  c_busy: cover property ($rose(busy_out));
  c_irq: cover property ($rose(irq_out));
  c_wake: cover property ($rose(wake_out));
endmodule

bind spiiw_top spiiw_chk #(.ADDR_W(ADDR_W)) i_spiiw_chk (
  .mclk_in(mclk_in), .rst_n_in(rst_n_in),
  .s_axi_awvalid_in(s_axi_awvalid_in), .s_axi_awready_out(s_axi_awready_out),
  .s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out),
  .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
  .s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
  .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in),
  .core_in(core_in), .irq_out(irq_out), .wake_out(wake_out), .busy_out(busy_out)
);

//--- test/spi_irq_wake_status_bench.sv
// Testbench: register, interrupt, wake and activity scenarios
`timescale 1ns/1ps
module spi_irq_wake_status_bench;
  import spiiw_pkg::*;
  logic        clk, rst_n, awv, awr, wv, wr, bv, br, arv, arr, rv, rr, irq, wake, busy;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rd;
  logic [3:0]  ws;
  logic [1:0]  bresp, rresp;
  spiiw_core_s core;
  int          errors = 0, check_count = 0, cycles = 0;

  spiiw_top i_spiiw_top (
    .mclk_in(clk), .rst_n_in(rst_n),
    .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_awaddr_in(awa),
    .s_axi_wvalid_in(wv), .s_axi_wready_out(wr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws),
    .s_axi_bvalid_out(bv), .s_axi_bready_in(br), .s_axi_bresp_out(bresp),
    .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_araddr_in(ara),
    .s_axi_rvalid_out(rv), .s_axi_rready_in(rr), .s_axi_rdata_out(rd),
    .s_axi_rresp_out(rresp), .core_in(core), .irq_out(irq), .wake_out(wake),
    .busy_out(busy)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      summarize();
    end
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    while (pa || pw) begin
      @(posedge clk);
      if (pa && awr) begin
        pa = 1'b0;
        awv <= 1'b0;
      end
      if (pw && wr) begin
        pw = 1'b0;
        wv <= 1'b0;
      end
    end
    do @(posedge clk); while (!bv);
    br <= 1'b0;
    chk(bresp, er);
    @(posedge clk);
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do @(posedge clk); while (!arr);
    arv <= 1'b0;
    do @(posedge clk); while (!rv);
    rr <= 1'b0;
    chk(rd, ed);
    chk(rresp, er);
    @(posedge clk);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    chk(irq, 1'b0);
    chk(wake, 1'b0);
    chk(busy, 1'b0);
    rd_reg(SPIIW_OFF_IRQ_EN, 32'h0, SPIIW_RESP_OKAY);
    rd_reg(SPIIW_OFF_WAKE_FL, 32'h0, SPIIW_RESP_OKAY);
    rd_reg(SPIIW_OFF_WAKE_EN, 32'h0, SPIIW_RESP_OKAY);
    rd_reg(SPIIW_OFF_STATUS, 32'h0, SPIIW_RESP_OKAY);
    rd_reg(8'h40, 32'h0, SPIIW_RESP_SLVERR);
    wr_reg(8'h40, 32'hFFFFFFFF, SPIIW_RESP_SLVERR);
    $display("test reset and map done");
  endtask

  task automatic t_irq();
    int b[13] = '{15, 14, 13, 12, 11, 9, 8, 5, 4, 3, 2, 1, 0};
    ws <= 4'h2;
    wr_reg(SPIIW_OFF_IRQ_EN, 32'hFFFFFFFF, SPIIW_RESP_OKAY);
    ws <= 4'hF;
    rd_reg(SPIIW_OFF_IRQ_EN, 32'h0000FB00, SPIIW_RESP_OKAY);
    wr_reg(SPIIW_OFF_IRQ_EN, 32'hFFFFFFFF, SPIIW_RESP_OKAY);
    rd_reg(SPIIW_OFF_IRQ_EN, 32'h0000FB3F, SPIIW_RESP_OKAY);
    core.evt_flags <= 16'h04C0;
    cyc(4);
    chk(irq, 1'b0);
    foreach (b[i]) begin
      core.evt_flags <= 16'h0001 << b[i];
      cyc(4);
      chk(irq, 1'b1);
      wr_reg(SPIIW_OFF_IRQ_EN, 32'h0000FB3F & ~(32'h1 << b[i]), SPIIW_RESP_OKAY);
      cyc(2);
      chk(irq, 1'b0);
      wr_reg(SPIIW_OFF_IRQ_EN, 32'h0000FB3F, SPIIW_RESP_OKAY);
    end
    core.master_mode <= 1'b1;
    core.evt_flags <= 16'h4000;
    cyc(4);
    chk(irq, 1'b0);
    core.evt_flags <= 16'h0000;
    core.master_mode <= 1'b0;
    wr_reg(SPIIW_OFF_IRQ_EN, 32'h0, SPIIW_RESP_OKAY);
    $display("test interrupt enables done");
  endtask

  task automatic t_wake();
    for (int i = 0; i < 4; i++) begin
      core.wake_cond <= 4'h1 << i;
      @(posedge clk);
      core.wake_cond <= 4'h0;
      cyc(4);
      chk(wake, 1'b0);
      rd_reg(SPIIW_OFF_WAKE_FL, 32'h1 << i, SPIIW_RESP_OKAY);
      wr_reg(SPIIW_OFF_WAKE_EN, 32'h1 << i, SPIIW_RESP_OKAY);
      cyc(2);
      chk(wake, 1'b1);
      wr_reg(SPIIW_OFF_WAKE_FL, 32'h0, SPIIW_RESP_OKAY);
      rd_reg(SPIIW_OFF_WAKE_FL, 32'h1 << i, SPIIW_RESP_OKAY);
      wr_reg(SPIIW_OFF_WAKE_FL, 32'h1 << i, SPIIW_RESP_OKAY);
      rd_reg(SPIIW_OFF_WAKE_FL, 32'h0, SPIIW_RESP_OKAY);
      chk(wake, 1'b0);
    end
    wr_reg(SPIIW_OFF_WAKE_EN, 32'hFFFFFFFF, SPIIW_RESP_OKAY);
    rd_reg(SPIIW_OFF_WAKE_EN, 32'h0000000F, SPIIW_RESP_OKAY);
    wr_reg(SPIIW_OFF_WAKE_EN, 32'h0, SPIIW_RESP_OKAY);
    $display("test wake flags done");
  endtask

  task automatic t_busy();
    wr_reg(SPIIW_OFF_EVT_MASK, 32'hFFFFFFFF, SPIIW_RESP_OKAY);
    rd_reg(SPIIW_OFF_EVT_MASK, 32'h3, SPIIW_RESP_OKAY);
    core.master_mode <= 1'b1;
    @(posedge clk);
    core.xfer_start <= 1'b1;
    @(posedge clk);
    core.xfer_start <= 1'b0;
    cyc(4);
    chk(busy, 1'b1);
    rd_reg(SPIIW_OFF_STATUS, 32'h1, SPIIW_RESP_OKAY);
    rd_reg(SPIIW_OFF_EVT_FL, 32'h1, SPIIW_RESP_OKAY);
    chk(irq, 1'b1);
    wr_reg(SPIIW_OFF_EVT_FL, 32'h1, SPIIW_RESP_OKAY);
    rd_reg(SPIIW_OFF_EVT_FL, 32'h0, SPIIW_RESP_OKAY);
    chk(irq, 1'b0);
    core.last_char <= 1'b1;
    @(posedge clk);
    core.last_char <= 1'b0;
    cyc(4);
    chk(busy, 1'b0);
    rd_reg(SPIIW_OFF_EVT_FL, 32'h2, SPIIW_RESP_OKAY);
    core.master_mode <= 1'b0;
    @(posedge clk);
    core.ss_active <= 1'b1;
    cyc(4);
    chk(busy, 1'b1);
    wr_reg(SPIIW_OFF_STATUS, 32'h0, SPIIW_RESP_OKAY);
    rd_reg(SPIIW_OFF_STATUS, 32'h1, SPIIW_RESP_OKAY);
    core.ss_active <= 1'b0;
    cyc(4);
    chk(busy, 1'b0);
    rd_reg(SPIIW_OFF_EVT_FL, 32'h3, SPIIW_RESP_OKAY);
    wr_reg(SPIIW_OFF_EVT_MASK, 32'h0, SPIIW_RESP_OKAY);
    wr_reg(SPIIW_OFF_EVT_FL, 32'h3, SPIIW_RESP_OKAY);
    rd_reg(SPIIW_OFF_EVT_FL, 32'h0, SPIIW_RESP_OKAY);
    chk(irq, 1'b0);
    $display("test activity done");
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    {awv, wv, br, arv, rr} = 5'h00;
    awa = 8'h00;
    ara = 8'h00;
    wd = 32'h0;
    ws = 4'hF;
    core = '0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_irq();
    t_wake();
    t_busy();
    summarize();
  end
endmodule
